// ==== abcm_chain.sv ====
/*
 * block chaining wrapper: chained and counter modes around an outside
 * single-block cipher core, with a valid/ready stream on both sides.
 * assumes the core holds its own keys, takes core_req as a level and
 * answers with a one-cycle core_ack carrying core_result.
 */
`timescale 1ns/1ps
module abcm_chain #(
	parameter int BLOCK_BYTES = 16
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [1:0]               mode,
	input  wire logic                     iv_load,
	input  wire logic [BLOCK_BYTES*8-1:0] iv_data,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [BLOCK_BYTES*8-1:0] in_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic      [BLOCK_BYTES*8-1:0] out_data,
	output logic                          core_req,
	output logic                          core_decrypt,
	output logic      [BLOCK_BYTES*8-1:0] core_block,
	input  wire logic                     core_ack,
	input  wire logic [BLOCK_BYTES*8-1:0] core_result,
	output logic                          busy
);
	localparam int W = BLOCK_BYTES * 8;

	abcm_pkg::abcm_state_t state_q;
	abcm_pkg::abcm_state_t state_d;
	logic [1:0]            mode_q;
	logic [W-1:0]          data_q;
	logic [W-1:0]          chain_q;
	logic [W-1:0]          block_q;
	logic [W-1:0]          block_d;
	logic [W-1:0]          out_q;
	logic [W-1:0]          out_d;
	logic [W-1:0]          ctr_value;
	logic                  mode_ok;
	logic                  accept;
	logic                  done;
	logic                  is_ctr;
	logic                  is_enc;
	logic                  iv_take;

	if (BLOCK_BYTES != abcm_pkg::BLOCK_BYTES) begin : g_chk
		$error("block width must match the cipher core");
	end

	assign mode_ok  = (mode == abcm_pkg::MODE_CBC_ENC) || (mode == abcm_pkg::MODE_CBC_DEC)
	                || (mode == abcm_pkg::MODE_CTR);
	// an unknown mode code stalls the input rather than guessing
	assign in_ready = (state_q == abcm_pkg::ABCM_IDLE) && mode_ok;
	assign accept   = in_valid && in_ready;
	assign done     = (state_q == abcm_pkg::ABCM_BUSY) && core_ack;
	assign is_ctr   = (mode_q == abcm_pkg::MODE_CTR);
	assign is_enc   = (mode_q == abcm_pkg::MODE_CBC_ENC);
	// a new vector is only taken between blocks so a chain is never split
	assign iv_take  = iv_load && (state_q == abcm_pkg::ABCM_IDLE) && !in_valid;

	// what the core sees, fixed at accept time
	assign block_d = (mode == abcm_pkg::MODE_CTR)     ? ctr_value :
	                 (mode == abcm_pkg::MODE_CBC_ENC) ? (in_data ^ chain_q) :
	                 in_data;

	// counter mode xors with the data in both directions
	assign out_d = is_ctr ? (core_result ^ data_q) :
	               is_enc ? core_result : (core_result ^ chain_q);

	always_comb begin
		state_d = state_q;
		case (state_q)
			abcm_pkg::ABCM_IDLE: begin
				if (accept) begin
					state_d = abcm_pkg::ABCM_BUSY;
				end
			end
			abcm_pkg::ABCM_BUSY: begin
				if (core_ack) begin
					state_d = abcm_pkg::ABCM_OUT;
				end
			end
			abcm_pkg::ABCM_OUT: begin
				if (out_ready) begin
					state_d = abcm_pkg::ABCM_IDLE;
				end
			end
			default: state_d = abcm_pkg::ABCM_IDLE;
		endcase
	end

	assign core_req     = (state_q == abcm_pkg::ABCM_BUSY);
	// only chained decryption ever asks for the inverse cipher
	assign core_decrypt = core_req && (mode_q == abcm_pkg::MODE_CBC_DEC);
	assign core_block   = block_q;
	assign out_valid    = (state_q == abcm_pkg::ABCM_OUT);
	assign out_data     = out_q;
	assign busy         = (state_q != abcm_pkg::ABCM_IDLE);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= abcm_pkg::ABCM_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q  <= abcm_pkg::MODE_CBC_ENC;
			data_q  <= W'(abcm_pkg::CHAIN_RESET);
			block_q <= W'(abcm_pkg::CHAIN_RESET);
		end else if (accept) begin
			mode_q  <= mode;
			data_q  <= in_data;
			block_q <= block_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_q <= W'(abcm_pkg::CHAIN_RESET);
		end else if (done) begin
			out_q <= out_d;
		end
	end

	// chained modes carry the ciphertext forward: encrypt keeps the core
	// result, decrypt keeps the incoming ciphertext
	always_ff @(posedge clk) begin
		if (rst) begin
			chain_q <= W'(abcm_pkg::CHAIN_RESET);
		end else if (iv_take) begin
			chain_q <= iv_data;
		end else if (done && !is_ctr) begin
			chain_q <= is_enc ? core_result : data_q;
		end
	end

	// the nonce, if any, arrives in the leading bytes of iv_data
	abcm_ctr #(
		.BYTES(BLOCK_BYTES)
	) u_ctr (
		.clk     (clk),
		.rst     (rst),
		.load    (iv_take),
		.load_val(iv_data),
		.step    (done && is_ctr),
		.value   (ctr_value)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ctr_done;
		done && is_ctr;
	endsequence

	sequence s_cbc_done;
		done && !is_ctr;
	endsequence

	a_ctr_forward_only: assert property (
		(accept && (mode == abcm_pkg::MODE_CTR)) |=> core_req && !core_decrypt
		&& (core_block == $past(ctr_value)))
		else $error("counter mode asked for the inverse cipher");

	a_ctr_step_once: assert property (
		s_ctr_done |=> (ctr_value == $past(ctr_value) + W'(abcm_pkg::CTR_STEP)))
		else $error("counter did not step by one after a block");

	a_ctr_full_hold: assert property (
		(!done && !iv_take) |=> $stable(ctr_value))
		else $error("counter changed without a block or load");

	a_ctr_big_endian: assert property (
		(s_ctr_done ##0 (ctr_value[7:0] == 8'hff)) |=> (ctr_value[7:0] == 8'h00)
		&& (ctr_value[W-1:8] == $past(ctr_value[W-1:8]) + (W-8)'(1)))
		else $error("last counter byte did not carry into the one before");

	a_ctr_xor_out: assert property (
		s_ctr_done |=> out_valid && (out_data == $past(core_result ^ data_q)))
		else $error("counter mode output is not data xor keystream");

	a_cbc_chain_next: assert property (
		(s_cbc_done ##0 is_enc) |=> (chain_q == $past(core_result)) && (out_data == chain_q))
		else $error("chained encryption did not carry the ciphertext forward");

	a_cbc_enc_input: assert property (
		(accept && (mode == abcm_pkg::MODE_CBC_ENC)) |=> core_req
		&& (core_block == $past(in_data ^ chain_q)))
		else $error("chained encryption did not mix the previous block");

	a_cbc_dec_out: assert property (
		(s_cbc_done ##0 !is_enc) |=> (out_data == $past(core_result ^ chain_q))
		&& (chain_q == $past(data_q)))
		else $error("chained decryption used the wrong previous block");

	a_out_hold: assert property (
		(out_valid && !out_ready) |=> out_valid && $stable(out_data))
		else $error("output dropped before it was taken");

	a_ctr_cbc_hold: assert property (
		s_cbc_done |=> $stable(ctr_value))
		else $error("counter stepped after a chained block");

	a_out_after_ack: assert property (
		done |=> out_valid && !core_req && !in_ready)
		else $error("result not offered right after the core answered");

	// a block on offer wins over a vector load
	a_load_refused: assert property (
		(iv_load && in_valid && !busy) |=> $stable(chain_q) && $stable(ctr_value))
		else $error("vector load taken while a block was offered");
endmodule

// ==== abcm_pkg.sv ====
/*
 * shared constants for the block chaining wrapper: block width,
 * mode codes and reset values.
 * assumes an external single-block cipher core of the same width.
 */
package abcm_pkg;
	localparam int          BLOCK_BYTES = 16;
	localparam int          BLOCK_BITS  = BLOCK_BYTES * 8;
	localparam logic [1:0]  MODE_CBC_ENC = 2'h0;
	localparam logic [1:0]  MODE_CBC_DEC = 2'h1;
	localparam logic [1:0]  MODE_CTR     = 2'h2;
	localparam logic [127:0] CHAIN_RESET = 128'h0;
	localparam logic [127:0] CTR_RESET   = 128'h0;
	localparam logic [127:0] CTR_STEP    = 128'h1;

	typedef enum logic [1:0] {
		ABCM_IDLE,
		ABCM_BUSY,
		ABCM_OUT
	} abcm_state_t;
endpackage

// ==== abcm_ctr.sv ====
/*
 * block-wide counter for counter mode: loadable, steps by one.
 * assumes load and step never come in the same cycle; load wins.
 */
`timescale 1ns/1ps
module abcm_ctr #(
	parameter int BYTES = 16
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               load,
	input  wire logic [BYTES*8-1:0] load_val,
	input  wire logic               step,
	output logic      [BYTES*8-1:0] value
);
	localparam int W = BYTES * 8;

	logic [BYTES*8-1:0] value_q;
	logic [BYTES*8-1:0] value_d;

	// byte 0 sits in the top bits, so a plain add carries from the last
	// byte toward the first, as a big-endian integer would
	function automatic logic [BYTES*8-1:0] be_inc(input logic [BYTES*8-1:0] v);
		be_inc = v + W'(abcm_pkg::CTR_STEP);
	endfunction

	if (BYTES != abcm_pkg::BLOCK_BYTES) begin : g_chk
		$error("counter must be exactly one cipher block wide");
	end

	assign value_d = load ? load_val : (step ? be_inc(value_q) : value_q);
	assign value   = value_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			value_q <= W'(abcm_pkg::CTR_RESET);
		end else begin
			value_q <= value_d;
		end
	end
endmodule

// ==== abcm_core_model.sv ====
/*
 * behavioural single-block cipher core for the wrapper bench.
 * assumes core_req is held as a level until the one-cycle ack.
 */
`timescale 1ns/1ps
module abcm_core_model (
	input  wire logic         clk,
	input  wire logic [3:0]   delay,
	input  wire logic         req,
	input  wire logic         decrypt,
	input  wire logic [127:0] block,
	output logic              ack,
	output logic      [127:0] result
);
	localparam logic [127:0] KEY = 128'h5a;
	logic [3:0]   cnt_q = 4'h0;
	logic [127:0] t;
	initial ack = 1'b0;
	initial result = 128'h0;
	assign t = block ^ KEY;
	always @(posedge clk) begin
		ack <= 1'b0;
		// stale result flips every cycle so it never passes for fresh data
		result <= ~result;
		if (req && !ack) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q >= delay) begin
				cnt_q <= 4'h0;
				ack <= 1'b1;
				result <= decrypt ? {t[7:0], t[127:8]} : ({block[119:0], block[127:120]} ^ KEY);
			end
		end
	end
endmodule

// ==== abcm_chain_test.sv ====
/*
 * self-checking bench for the block chaining wrapper.
 * assumes the core model's toy cipher; expectations are recomputed here.
 */
`timescale 1ns/1ps
module abcm_chain_test;
	localparam logic [127:0] KEY = 128'h5a;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic [1:0]   mode = 2'h0;
	logic         iv_load = 1'b0;
	logic [127:0] iv_data = 128'h0;
	logic         in_valid = 1'b0;
	logic [127:0] in_data = 128'h0;
	logic         out_ready = 1'b0;
	logic [3:0]   delay = 4'h0;
	logic         in_ready, out_valid, core_req, core_decrypt, core_ack, busy;
	logic [127:0] out_data, core_block, core_result;
	logic         dseen = 1'b0;
	int           errors = 0;
	int           samples_checked = 0;
	always #2.5 clk = ~clk;
	abcm_chain dut_u (.clk(clk), .rst(rst), .mode(mode), .iv_load(iv_load), .iv_data(iv_data),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .core_req(core_req),
		.core_decrypt(core_decrypt), .core_block(core_block), .core_ack(core_ack),
		.core_result(core_result), .busy(busy));
	abcm_core_model core_u (.clk(clk), .delay(delay), .req(core_req), .decrypt(core_decrypt),
		.block(core_block), .ack(core_ack), .result(core_result));
	function automatic logic [127:0] enc(logic [127:0] x);
		return {x[119:0], x[127:120]} ^ KEY;
	endfunction
	function automatic logic [127:0] dec(logic [127:0] y);
		logic [127:0] t;
		t = y ^ KEY;
		return {t[7:0], t[127:8]};
	endfunction
	task automatic check(string what, logic [127:0] exp, logic [127:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic load(logic [127:0] v);
		iv_load = 1'b1;
		iv_data = v;
		@(negedge clk) iv_load = 1'b0;
	endtask
	task automatic xfer(logic [127:0] din, logic [127:0] exp);
		int n;
		n = 0;
		in_valid = 1'b1;
		in_data = din;
		while (!in_ready && n < 50) begin
			@(negedge clk) n++;
		end
		@(negedge clk) in_valid = 1'b0;
		while (!out_valid && n < 100) begin
			dseen |= core_req & core_decrypt;
			@(negedge clk) n++;
		end
		check("out_valid", 128'h1, {127'h0, out_valid});
		check("out_data", exp, out_data);
		check("in_ready", 128'h0, {127'h0, in_ready});
		check("busy", 128'h1, {127'h0, busy});
		// hold off one cycle: the result must stand until taken
		@(negedge clk) check("out_data held", exp, out_data);
		out_ready = 1'b1;
		@(negedge clk) out_ready = 1'b0;
	endtask
	task automatic test_cbc;
		logic [127:0] iv, c1;
		iv = 128'h0f0e0d0c0b0a09080706050403020100;
		c1 = enc(128'h11 ^ iv);
		mode = 2'h0;
		load(iv);
		xfer(128'h11, c1);
		xfer(128'h22, enc(128'h22 ^ c1));
		mode = 2'h1;
		delay = 4'h5;
		load(iv);
		xfer(c1, 128'h11);
		xfer(enc(128'h22 ^ c1), 128'h22);
		delay = 4'h0;
	endtask
	task automatic test_ctr;
		logic [127:0] c;
		c = {64'h1122334455667788, 64'hffffffffffffffff};
		mode = 2'h2;
		dseen = 1'b0;
		load(c);
		xfer(128'h33, enc(c) ^ 128'h33);
		xfer(128'h44, enc({64'h1122334455667789, 64'h0}) ^ 128'h44);
		load({128{1'b1}});
		// decrypt direction: feed back cipher text, expect plain text
		xfer(enc({128{1'b1}}) ^ 128'h55, 128'h55);
		xfer(enc(128'h0) ^ 128'h66, 128'h66);
		check("core_decrypt", 128'h0, {127'h0, dseen});
	endtask
	task automatic test_bad_mode;
		mode = 2'h3;
		in_valid = 1'b1;
		iv_load = 1'b1;
		iv_data = 128'h0;
		@(negedge clk) check("in_ready", 128'h0, {127'h0, in_ready});
		check("busy", 128'h0, {127'h0, busy});
		iv_load = 1'b0;
		mode = 2'h0;
		// the vector above was refused, so the chain still holds all ones
		xfer(128'h77, enc(128'h77 ^ {128{1'b1}}));
	endtask
	task automatic give_verdict;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		test_cbc();
		test_ctr();
		test_bad_mode();
		give_verdict();
	end
	// whole run is well under a thousand cycles
	initial begin
		#20000;
		errors++;
		give_verdict();
	end
endmodule
